// ### ldcr_fault_cnt.sv
// consecutive framing/parity fault counter with programmable threshold
`timescale 1ns/1ps
`default_nettype none
module ldcr_fault_cnt #(
	parameter int CNT_W = 4
) (
	// clocking
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic soft_rst,
	// events
	input wire logic fault,
	input wire logic good,
	input wire logic [CNT_W-1:0] limit,
	// result
	output logic trip,
	output logic [CNT_W:0] count_q
);
	// one extra bit so threshold 16 is reachable
	logic [CNT_W:0] thresh;
	assign thresh = {1'b0, limit} + {{CNT_W{1'b0}}, 1'b1};
	assign trip = ce && fault && (count_q + 1'b1 >= thresh);
	always_ff @(posedge clock) begin
		if (rst) begin
			count_q <= '0;
		end else if (ce) begin
			if (soft_rst || good || trip) begin
				count_q <= '0;
			end else if (fault) begin
				count_q <= count_q + 1'b1;
			end
		end
	end
endmodule : ldcr_fault_cnt
`default_nettype wire

// ### ldcr_master.sv
// link master model driving decoder-side requests into the bank
`timescale 1ns/1ps
`default_nettype none
module ldcr_master (
	// clock
	input wire logic clock,
	// requests
	output var ldcr_pkg::ldcr_wr_s reg_wr,
	output logic code_wr,
	output logic [ldcr_pkg::CODE_W-1:0] code_data,
	output logic frame_ok,
	output var ldcr_pkg::ldcr_fault_s fault_in
);
	import ldcr_pkg::*;
	initial begin
		reg_wr = '0;
		code_wr = 1'b0;
		code_data = '0;
		frame_ok = 1'b0;
		fault_in = '0;
	end
	function automatic logic [7:0] fmask(input logic [2:0] a);
		case (a)
		OFF_CFG1: fmask = CFG1_MASK;
		OFF_CFG2: fmask = CFG2_MASK;
		OFF_CFG3: fmask = CFG3_MASK;
		default: fmask = 8'hff;
		endcase
	endfunction : fmask
	// each request holds one cycle, then one idle cycle before the next
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		reg_wr = '{1'b1, a, d & fmask(a)};
		@(negedge clock);
		reg_wr.wr = 1'b0;
		@(negedge clock);
	endtask : wr
	task automatic code(input logic [15:0] d);
		code_wr = 1'b1;
		code_data = d;
		@(negedge clock);
		code_wr = 1'b0;
		code_data = ~d;
		@(negedge clock);
	endtask : code
	task automatic frame();
		frame_ok = 1'b1;
		@(negedge clock);
		frame_ok = 1'b0;
		@(negedge clock);
	endtask : frame
	task automatic fault(input logic [3:0] f);
		fault_in = f;
		@(negedge clock);
		fault_in = '0;
		@(negedge clock);
	endtask : fault
endmodule : ldcr_master
`default_nettype wire

// ### ldcr_pkg.sv
// shared constants and types for the loop dac configuration register bank
`default_nettype none
package ldcr_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int CODE_W = 16;
	localparam int CNT_W = 4;
	// register offsets
	localparam logic [ADDR_W-1:0] OFF_LOCK = 3'h0;
	localparam logic [ADDR_W-1:0] OFF_CFG1 = 3'h1;
	localparam logic [ADDR_W-1:0] OFF_CFG2 = 3'h2;
	localparam logic [ADDR_W-1:0] OFF_CFG3 = 3'h3;
	localparam logic [ADDR_W-1:0] OFF_ERRLO = 3'h4;
	localparam logic [ADDR_W-1:0] OFF_ERRHI = 3'h5;
	// reset values
	localparam logic [DATA_W-1:0] RST_LOCK = 8'h00;
	localparam logic [DATA_W-1:0] RST_CFG1 = 8'h08;
	localparam logic [DATA_W-1:0] RST_CFG2 = 8'h1f;
	localparam logic [DATA_W-1:0] RST_CFG3 = 8'h08;
	localparam logic [DATA_W-1:0] RST_ERRLO = 8'h24;
	localparam logic [DATA_W-1:0] RST_ERRHI = 8'he8;
	localparam logic [CODE_W-1:0] RST_CODE = 16'h0000;
	localparam logic [DATA_W-1:0] UNLOCK_KEY = 8'h95;
	localparam logic [DATA_W-1:0] LOW_BYTE_ERR = 8'h00;
	// field positions
	localparam int CFG1_SRST = 0;
	localparam int CFG1_FRC_LO = 3;
	localparam int CFG1_FRC_HI = 4;
	localparam int CFG2_LOOP = 0;
	localparam int CFG2_CHAN = 1;
	localparam int CFG2_PAR = 2;
	localparam int CFG2_FRAME = 3;
	localparam int CFG2_ACK = 4;
	localparam logic [DATA_W-1:0] CFG1_MASK = 8'h19;
	localparam logic [DATA_W-1:0] CFG2_MASK = 8'h1f;
	localparam logic [DATA_W-1:0] CFG3_MASK = 8'h0f;
	localparam logic [1:0] FRC_SET = 2'h1;
	localparam logic [1:0] FRC_CLR = 2'h2;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

	typedef struct packed {
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} ldcr_wr_s;

	typedef struct packed {
		logic frame_err;
		logic parity_err;
		logic chan_idle;
		logic loop_err;
	} ldcr_fault_s;

	typedef struct packed {
		logic frame;
		logic parity;
		logic chan;
		logic loop;
	} ldcr_rpt_s;
endpackage : ldcr_pkg
`default_nettype wire

// ### ldcr_reg8.sv
// one eight-bit configuration register with masked write and reset value
`timescale 1ns/1ps
`default_nettype none
module ldcr_reg8 #(
	parameter logic [7:0] RST_VAL = 8'h00,
	parameter logic [7:0] MASK = 8'hff
) (
	// clocking
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// write side
	input wire logic soft_rst,
	input wire logic we,
	input wire logic [7:0] wdata,
	// value
	output logic [7:0] q
);
	always_ff @(posedge clock) begin
		if (rst) begin
			q <= RST_VAL;
		end else if (ce) begin
			if (soft_rst) begin
				q <= RST_VAL;
			end else if (we) begin
				// reserved bits held at zero
				q <= wdata & MASK;
			end
		end
	end
endmodule : ldcr_reg8
`default_nettype wire

// ### ldcr_top.sv
// loop dac configuration register bank with error state and code select
// Functional notes
// [R1] 0x95 to lock register unlocks, else locks
// [R2] locked bank ignores configuration writes
// [R3] output code frozen while bank unlocked
// [R4] force field: 01 sets, 10 clears error
// [R5] error condition set at power-on
// [R6] valid frame clears error condition
// [R7] force field self-clears after write
// [R8] cleared error restores previously held code
// [R9] soft reset bit equals power-on, self-clears
// [R10] ack enable acknowledges every valid frame
// [R11] framing error reported only when enabled
// [R12] parity error reported only when enabled
// [R13] channel-inactive reported only when enabled
// [R14] loop error reported only when enabled
// [R15] error after 1+count consecutive frame/parity faults
// [R16] low band: low byte upper, 0x00 lower
// [R17] high band: high byte upper, 0x00 lower
// [R18] master writes zeros to reserved bits
// [R19] 16-bit output code, replaced during error
// [R20] all registers default on both resets
`timescale 1ns/1ps
`default_nettype none
module ldcr_top #(
	parameter int CNT_W = ldcr_pkg::CNT_W
) (
	// clocking
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// register writes and reads from the frame decoder
	input wire ldcr_pkg::ldcr_wr_s reg_wr,
	input wire logic [ldcr_pkg::ADDR_W-1:0] rd_addr,
	output logic [ldcr_pkg::DATA_W-1:0] rd_data,
	// data code writes from the frame decoder
	input wire logic code_wr,
	input wire logic [ldcr_pkg::CODE_W-1:0] code_data,
	// frame decoder events
	input wire logic frame_ok,
	input wire ldcr_pkg::ldcr_fault_s fault_in,
	// error band select pin
	input wire logic error_band_select,
	// outputs to loop drive and link
	output logic [ldcr_pkg::CODE_W-1:0] output_code,
	output logic ack_req,
	output var ldcr_pkg::ldcr_rpt_s report,
	output logic error_q,
	output logic unlocked_q
);
	import ldcr_pkg::*;

	logic [DATA_W-1:0] lock_q, cfg1_q, cfg2_q, cfg3_q, errlo_q, errhi_q;
	logic [CODE_W-1:0] held_code_q;
	logic [CNT_W:0] fault_count;
	logic soft_rst_q, wr_lock, wr_cfg, fault_trip, frc_set, frc_clr;
	logic [1:0] frc;

	// soft reset is taken one cycle after the write, then clears
	always_ff @(posedge clock) begin
		if (rst) begin
			soft_rst_q <= 1'b0;
		end else if (ce) begin
			soft_rst_q <= wr_cfg && reg_wr.addr == OFF_CFG1 &&
				reg_wr.data[CFG1_SRST] && !soft_rst_q; // R9
		end
	end

	assign wr_lock = reg_wr.wr && reg_wr.addr == OFF_LOCK;
	// lock register itself is always writable, so the bank can be opened
	assign wr_cfg = reg_wr.wr && unlocked_q; // R2

	always_ff @(posedge clock) begin
		if (rst) begin
			lock_q <= RST_LOCK;
		end else if (ce) begin
			if (soft_rst_q) begin
				lock_q <= RST_LOCK; // R20
			end else if (wr_lock) begin
				lock_q <= reg_wr.data; // R1
			end
		end
	end
	// flop twin of the key compare keeps the status pin glitch free
	always_ff @(posedge clock) begin
		if (rst) begin
			unlocked_q <= (RST_LOCK == UNLOCK_KEY);
		end else if (ce) begin
			if (soft_rst_q) begin
				unlocked_q <= (RST_LOCK == UNLOCK_KEY); // R20
			end else if (wr_lock) begin
				unlocked_q <= reg_wr.data == UNLOCK_KEY; // R1
			end
		end
	end

	// configuration registers; reserved bits masked to zero
	ldcr_reg8 #(.RST_VAL(RST_CFG2), .MASK(CFG2_MASK)) u_cfg2 (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.soft_rst(soft_rst_q),
		.we(wr_cfg && reg_wr.addr == OFF_CFG2),
		.wdata(reg_wr.data),
		.q(cfg2_q)
	); // R18
	ldcr_reg8 #(.RST_VAL(RST_CFG3), .MASK(CFG3_MASK)) u_cfg3 (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.soft_rst(soft_rst_q),
		.we(wr_cfg && reg_wr.addr == OFF_CFG3),
		.wdata(reg_wr.data),
		.q(cfg3_q)
	);
	ldcr_reg8 #(.RST_VAL(RST_ERRLO)) u_errlo (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.soft_rst(soft_rst_q),
		.we(wr_cfg && reg_wr.addr == OFF_ERRLO),
		.wdata(reg_wr.data),
		.q(errlo_q)
	);
	ldcr_reg8 #(.RST_VAL(RST_ERRHI)) u_errhi (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.soft_rst(soft_rst_q),
		.we(wr_cfg && reg_wr.addr == OFF_ERRHI),
		.wdata(reg_wr.data),
		.q(errhi_q)
	);

	// error_force_and_soft_reset command bits never persist, only the default with those bits cleared (0x00) is read
	assign cfg1_q = RST_CFG1 & ~CFG1_MASK; // R7
	assign frc = reg_wr.data[CFG1_FRC_HI:CFG1_FRC_LO];
	assign frc_set = wr_cfg && reg_wr.addr == OFF_CFG1 && frc == FRC_SET; // R4
	assign frc_clr = wr_cfg && reg_wr.addr == OFF_CFG1 && frc == FRC_CLR; // R4

	ldcr_fault_cnt #(.CNT_W(CNT_W)) u_cnt (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.soft_rst(soft_rst_q),
		.fault(fault_in.frame_err || fault_in.parity_err),
		.good(frame_ok),
		.limit(cfg3_q[CNT_W-1:0]),
		.trip(fault_trip),
		.count_q(fault_count)
	); // R15

	// error condition; a set in the same cycle as a clear wins
	always_ff @(posedge clock) begin
		if (rst) begin
			error_q <= 1'b1; // R5
		end else if (ce) begin
			if (soft_rst_q || frc_set || fault_trip) begin
				error_q <= 1'b1; // R9 R4 R15
			end else if (frc_clr || frame_ok) begin
				error_q <= 1'b0; // R4 R6
			end
		end
	end

	// held code survives error so clearing restores it
	always_ff @(posedge clock) begin
		if (rst) begin
			held_code_q <= RST_CODE;
		end else if (ce) begin
			if (soft_rst_q) begin
				held_code_q <= RST_CODE; // R20
			end else if (code_wr && !unlocked_q) begin
				held_code_q <= code_data; // R3 R8
			end
		end
	end

	// output register; error bytes replace held code
	always_ff @(posedge clock) begin
		if (rst) begin
			output_code <= {RST_ERRLO, LOW_BYTE_ERR};
		end else if (ce) begin
			if (error_q && error_band_select) begin
				output_code <= {errhi_q, LOW_BYTE_ERR}; // R17 R19
			end else if (error_q) begin
				output_code <= {errlo_q, LOW_BYTE_ERR}; // R16 R19
			end else begin
				output_code <= held_code_q; // R8 R19
			end
		end
	end

	// acknowledge and report gating
	assign ack_req = frame_ok && cfg2_q[CFG2_ACK]; // R10
	always_ff @(posedge clock) begin
		if (rst) begin
			report <= '0;
		end else if (ce) begin
			report.frame <= fault_in.frame_err && cfg2_q[CFG2_FRAME]; // R11
			report.parity <= fault_in.parity_err && cfg2_q[CFG2_PAR]; // R12
			report.chan <= fault_in.chan_idle && cfg2_q[CFG2_CHAN]; // R13
			report.loop <= fault_in.loop_err && cfg2_q[CFG2_LOOP]; // R14
		end
	end

	// read data registered
	always_ff @(posedge clock) begin
		if (rst) begin
			rd_data <= ZERO_BYTE;
		end else if (ce) begin
			case (rd_addr)
				OFF_LOCK: rd_data <= lock_q;
				OFF_CFG1: rd_data <= cfg1_q;
				OFF_CFG2: rd_data <= cfg2_q;
				OFF_CFG3: rd_data <= cfg3_q;
				OFF_ERRLO: rd_data <= errlo_q;
				OFF_ERRHI: rd_data <= errhi_q;
				default: rd_data <= ZERO_BYTE;
			endcase
		end
	end

	// assertions
	unlock_key_a: assert property (@(posedge clock) disable iff (rst) // R1
		ce && wr_lock && !soft_rst_q |=> unlocked_q == ($past(reg_wr.data) == UNLOCK_KEY))
		else $error("lock state not from written key");
	locked_hold_a: assert property (@(posedge clock) disable iff (rst) // R2
		ce && !unlocked_q && !soft_rst_q |=> $stable(cfg2_q) && $stable(errhi_q))
		else $error("locked register changed");
	code_frozen_a: assert property (@(posedge clock) disable iff (rst) // R3
		ce && unlocked_q && !soft_rst_q |=> $stable(held_code_q))
		else $error("code updated while unlocked");
	force_set_a: assert property (@(posedge clock) disable iff (rst) // R4
		ce && frc_set |=> error_q)
		else $error("forced set missed");
	force_clr_a: assert property (@(posedge clock) disable iff (rst) // R4
		ce && frc_clr && !frc_set && !fault_trip && !soft_rst_q |=> !error_q)
		else $error("forced clear missed");
	frame_clr_a: assert property (@(posedge clock) disable iff (rst) // R6
		ce && frame_ok && !frc_set && !fault_trip && !soft_rst_q |=> !error_q)
		else $error("valid frame did not clear error");
	cfg1_read_a: assert property (@(posedge clock) disable iff (rst) // R7
		ce && rd_addr == OFF_CFG1 |=> rd_data[CFG1_FRC_HI:CFG1_FRC_LO] == 2'h0)
		else $error("force field persisted");
	soft_rst_a: assert property (@(posedge clock) disable iff (rst) // R9
		soft_rst_q && ce |=> error_q && !soft_rst_q && cfg2_q == RST_CFG2)
		else $error("soft reset incomplete");
	ack_gate_a: assert property (@(posedge clock) disable iff (rst) // R10
		ack_req == (frame_ok && cfg2_q[CFG2_ACK]) && (!ack_req || frame_ok))
		else $error("ack gating wrong");
	frame_rpt_a: assert property (@(posedge clock) disable iff (rst) // R11
		ce ##1 report.frame |-> $past(cfg2_q[CFG2_FRAME]))
		else $error("framing report while disabled");
	trip_err_a: assert property (@(posedge clock) disable iff (rst) // R15
		ce && fault_trip |=> error_q)
		else $error("threshold did not set error");
	err_code_a: assert property (@(posedge clock) disable iff (rst) // R16
		ce && error_q && !error_band_select |=>
		output_code == {$past(errlo_q), LOW_BYTE_ERR})
		else $error("low band code wrong");
	hi_code_a: assert property (@(posedge clock) disable iff (rst) // R17
		ce && error_q && error_band_select |=>
		output_code == {$past(errhi_q), LOW_BYTE_ERR})
		else $error("high band code wrong");
	restore_a: assert property (@(posedge clock) disable iff (rst) // R8
		ce && !error_q |=> output_code == $past(held_code_q))
		else $error("held code not restored");
	lock_match_a: assert property (@(posedge clock) disable iff (rst) // R1
		unlocked_q == (lock_q == UNLOCK_KEY))
		else $error("lock status differs from lock register");
	lock_other_a: assert property (@(posedge clock) disable iff (rst) // R1
		ce && wr_lock && reg_wr.data != UNLOCK_KEY |=> !unlocked_q)
		else $error("other value did not lock");
	locked_more_a: assert property (@(posedge clock) disable iff (rst) // R2
		ce && !unlocked_q && !soft_rst_q |=>
		$stable(cfg3_q) && $stable(errlo_q))
		else $error("locked register changed");
	code_take_a: assert property (@(posedge clock) disable iff (rst) // R3
		ce && code_wr && !unlocked_q && !soft_rst_q |=>
		held_code_q == $past(code_data))
		else $error("locked code write not taken");
	power_err_a: assert property (@(posedge clock) disable iff (rst) // R5
		$fell(rst) |-> error_q && output_code == {RST_ERRLO, LOW_BYTE_ERR})
		else $error("no error condition after reset");
	soft_arm_a: assert property (@(posedge clock) disable iff (rst) // R9
		ce && wr_cfg && reg_wr.addr == OFF_CFG1 && reg_wr.data[CFG1_SRST] &&
		!soft_rst_q |=> soft_rst_q)
		else $error("soft reset not armed");
	ack_on_a: assert property (@(posedge clock) disable iff (rst) // R10
		frame_ok && cfg2_q[CFG2_ACK] |-> ack_req)
		else $error("enabled ack missing");
	ack_off_a: assert property (@(posedge clock) disable iff (rst) // R10
		!cfg2_q[CFG2_ACK] |-> !ack_req)
		else $error("ack while disabled");
	frame_pass_a: assert property (@(posedge clock) disable iff (rst) // R11
		ce && fault_in.frame_err && cfg2_q[CFG2_FRAME] |=> report.frame)
		else $error("enabled framing report missing");
	parity_pass_a: assert property (@(posedge clock) disable iff (rst) // R12
		ce && fault_in.parity_err && cfg2_q[CFG2_PAR] |=> report.parity)
		else $error("enabled parity report missing");
	parity_block_a: assert property (@(posedge clock) disable iff (rst) // R12
		ce ##1 report.parity |-> $past(cfg2_q[CFG2_PAR]))
		else $error("parity report while disabled");
	chan_pass_a: assert property (@(posedge clock) disable iff (rst) // R13
		ce && fault_in.chan_idle && cfg2_q[CFG2_CHAN] |=> report.chan)
		else $error("enabled channel report missing");
	chan_block_a: assert property (@(posedge clock) disable iff (rst) // R13
		ce ##1 report.chan |-> $past(cfg2_q[CFG2_CHAN]))
		else $error("channel report while disabled");
	loop_pass_a: assert property (@(posedge clock) disable iff (rst) // R14
		ce && fault_in.loop_err && cfg2_q[CFG2_LOOP] |=> report.loop)
		else $error("enabled loop report missing");
	loop_block_a: assert property (@(posedge clock) disable iff (rst) // R14
		ce ##1 report.loop |-> $past(cfg2_q[CFG2_LOOP]))
		else $error("loop report while disabled");
	count_clr_a: assert property (@(posedge clock) disable iff (rst) // R15
		ce && frame_ok |=> fault_count == '0)
		else $error("valid frame did not clear fault count");
	count_step_a: assert property (@(posedge clock) disable iff (rst) // R15
		ce && (fault_in.frame_err || fault_in.parity_err) && !frame_ok &&
		!fault_trip && !soft_rst_q |=> fault_count == $past(fault_count) + 1'b1)
		else $error("fault not counted");
	reset_dflt_a: assert property (@(posedge clock) disable iff (rst) // R20
		$fell(rst) |-> lock_q == RST_LOCK && cfg2_q == RST_CFG2 &&
		cfg3_q == RST_CFG3 && errlo_q == RST_ERRLO && errhi_q == RST_ERRHI &&
		held_code_q == RST_CODE)
		else $error("register not at default after reset");
	soft_dflt_a: assert property (@(posedge clock) disable iff (rst) // R20
		ce && soft_rst_q |=> lock_q == RST_LOCK && !unlocked_q &&
		cfg3_q == RST_CFG3 && errlo_q == RST_ERRLO && errhi_q == RST_ERRHI &&
		held_code_q == RST_CODE)
		else $error("register not at default after soft reset");
	rsvd_zero_a: assert property (@(posedge clock) disable iff (rst) // R18
		(cfg2_q & ~CFG2_MASK) == ZERO_BYTE &&
		(cfg3_q & ~CFG3_MASK) == ZERO_BYTE)
		else $error("reserved bit stored");
	rd_lock_a: assert property (@(posedge clock) disable iff (rst) // R1
		ce && rd_addr == OFF_LOCK |=> rd_data == $past(lock_q))
		else $error("lock register read wrong");
	rd_spare_a: assert property (@(posedge clock) disable iff (rst) // R20
		ce && rd_addr > OFF_ERRHI |=> rd_data == ZERO_BYTE)
		else $error("unused address read not zero");
	ce_freeze_a: assert property (@(posedge clock) disable iff (rst) // R2
		!ce |=> $stable(error_q) && $stable(output_code) && $stable(lock_q) &&
		$stable(cfg2_q) && $stable(held_code_q) && $stable(report))
		else $error("state moved while clock enable low");
	force_cover_c: cover property (@(posedge clock) frc_set ##[1:20] frc_clr);
	trip_cover_c: cover property (@(posedge clock) fault_trip);
	unlock_cover_c: cover property (@(posedge clock) unlocked_q ##1 soft_rst_q);
	freeze_cover_c: cover property (@(posedge clock) !ce ##1 ce);
	band_cover_c: cover property (@(posedge clock) error_q && error_band_select);
endmodule : ldcr_top
`default_nettype wire

// ### ldcr_top_tb_top.sv
// self-checking testbench for the loop dac configuration register bank
`timescale 1ns/1ps
`default_nettype none
module ldcr_top_tb_top;
	import ldcr_pkg::*;
	typedef struct {int sel; logic [15:0] v; int due;} ldcr_note_s;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic band = 1'b0;
	logic ce = 1'b1;
	logic [2:0] rd_addr = '0;
	logic [7:0] rd_data;
	logic [15:0] output_code, code_data, held, obs;
	logic ack_req, ack_d, error_q, unlocked_q, code_wr, frame_ok, err, unl;
	ldcr_rpt_s report;
	ldcr_wr_s reg_wr;
	ldcr_fault_s fault_in;
	ldcr_note_s q[$];
	ldcr_note_s n;
	logic [7:0] shadow [0:7];
	logic [31:0] r;
	int cyc = 0;
	int miscompares = 0;
	int comparisons = 0;
	int seed = 32'hb9d3e499;
	always #20 clock = ~clock;
	ldcr_master u_m (.clock(clock), .reg_wr(reg_wr), .code_wr(code_wr),
		.code_data(code_data), .frame_ok(frame_ok), .fault_in(fault_in));
	ldcr_top u_dut (.clock(clock), .rst(rst), .ce(ce), .reg_wr(reg_wr),
		.rd_addr(rd_addr), .rd_data(rd_data), .code_wr(code_wr),
		.code_data(code_data), .frame_ok(frame_ok), .fault_in(fault_in),
		.error_band_select(band), .output_code(output_code),
		.ack_req(ack_req), .report(report), .error_q(error_q),
		.unlocked_q(unlocked_q));
	task automatic end_sim();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	always @(posedge clock) begin
		cyc <= cyc + 1;
		ack_d <= ack_req;
		if (cyc > 2000) begin
			miscompares++;
			end_sim();
		end
	end
	// notes fall due on cycle counts, so no strobe races the monitor
	always @(negedge clock) begin
		while (q.size() > 0 && q[0].due <= cyc) begin
			n = q.pop_front();
			case (n.sel)
			0: obs = {8'h00, rd_data};
			1: obs = output_code;
			2: obs = {15'h0000, error_q};
			3: obs = {12'h000, report};
			4: obs = {15'h0000, unlocked_q};
			default: obs = {15'h0000, ack_d};
			endcase
			comparisons++;
			if (obs !== n.v)
				$display("MISMATCH %0t sel %0d got %h exp %h", $time, n.sel,
					obs, n.v);
			if (obs !== n.v)
				miscompares++;
		end
	end
	task automatic note(input int sel, input logic [15:0] v);
		q.push_back('{sel, v, cyc + 1});
	endtask : note
	task automatic defaults();
		shadow = '{RST_LOCK, 8'h00, RST_CFG2, RST_CFG3, RST_ERRLO, RST_ERRHI,
			8'h00, 8'h00};
		err = 1'b1;
		held = RST_CODE;
		unl = 1'b0;
	endtask : defaults
	task automatic wr(input logic [2:0] a, input logic [7:0] d, input bit upd);
		if (upd)
			shadow[a] = d & u_m.fmask(a);
		u_m.wr(a, d);
	endtask : wr
	task automatic chk_all();
		repeat (2) @(negedge clock);
		for (int a = 0; a < 8; a++) begin
			rd_addr = a[2:0];
			note(0, {8'h00, shadow[a]});
			@(negedge clock);
		end
		note(1, err ? {band ? shadow[5] : shadow[4], LOW_BYTE_ERR} : held);
		note(2, {15'h0000, err});
		note(4, {15'h0000, unl});
		@(negedge clock);
	endtask : chk_all
	task automatic frame();
		note(5, {15'h0000, shadow[2][CFG2_ACK]});
		u_m.frame();
		err = 1'b0;
	endtask : frame
	task automatic fault(input logic [3:0] f);
		note(3, {12'h000, f & shadow[2][3:0]});
		u_m.fault(f);
	endtask : fault
	initial begin
		defaults();
		repeat (5) @(negedge clock);
		rst = 1'b0;
		chk_all();
		wr(OFF_CFG2, 8'h00, 0);
		wr(OFF_LOCK, UNLOCK_KEY, 1);
		unl = 1'b1;
		for (int a = 2; a < 8; a++) begin
			r = $random(seed);
			wr(a[2:0], r[7:0], a < 6);
		end
		chk_all();
		r = $random(seed);
		wr(OFF_LOCK, (r[7:0] == UNLOCK_KEY) ? 8'h00 : r[7:0], 1);
		unl = 1'b0;
		frame();
		r = $random(seed);
		held = r[15:0];
		u_m.code(held);
		chk_all();
		wr(OFF_LOCK, UNLOCK_KEY, 1);
		unl = 1'b1;
		u_m.code(~held);
		// write dropped while the bank is frozen
		ce = 1'b0;
		wr(OFF_ERRLO, ~shadow[4], 0);
		ce = 1'b1;
		for (int k = 0; k < 4; k++) begin
			band = k[0];
			wr(OFF_CFG1, k[1:0] << 3, 0);
			if (k == 1)
				err = 1'b1;
			if (k == 2)
				err = 1'b0;
			chk_all();
		end
		for (int e = 0; e < 2; e++) begin
			wr(OFF_CFG2, e ? 8'h1f : 8'h00, 1);
			frame();
			for (int b = 0; b < 4; b++)
				fault(4'h1 << b);
		end
		wr(OFF_CFG3, 8'h01, 1);
		frame();
		fault(4'h4);
		frame();
		fault(4'h4);
		chk_all();
		fault(4'h8);
		err = 1'b1;
		chk_all();
		wr(OFF_CFG1, 8'h01, 0);
		repeat (2) @(negedge clock);
		defaults();
		chk_all();
		// let the monitor take the last notes before the verdict
		repeat (2) @(negedge clock);
		end_sim();
	end
endmodule : ldcr_top_tb_top
`default_nettype wire
